// ### src/pmc_clear_delay.sv
// delays the wake flag clear strobe by a fixed number of clock cycles
`timescale 1ns/1ps
`default_nettype none

module pmc_clear_delay #(
  parameter int DEPTH = 2
) (
  input  wire logic ref_clk, // system clock
  input  wire logic sys_rst, // async reset, active high
  input  wire logic clr_req, // one-cycle clear request
  output logic      clr_fire // one-cycle clear, DEPTH cycles later
);

  typedef struct packed {
    logic [DEPTH-1:0] pipe;
  } pmc_dly_state_t;

  pmc_dly_state_t s_r;
  pmc_dly_state_t s_nxt;

  // shift the request along; a second request simply rides behind
  always_comb begin
    s_nxt      = s_r;
    s_nxt.pipe = {s_r.pipe[DEPTH-2:0], clr_req};
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign clr_fire = s_r.pipe[DEPTH-1];

  a_fire_after_req: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clr_req |-> ##2 clr_fire
  ) else $error("wake clear did not fire two cycles after request");

endmodule

`default_nettype wire

// ### src/pmc_pkg.sv
// shared offsets, field positions, reset values and modes of the power regs
package pmc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;

  // ----------------------------------------------------------------
  // power_control field positions
  // ----------------------------------------------------------------
  localparam int          CTRL_LP_BIT     = 0;
  localparam int          CTRL_SBSEL_BIT  = 1;
  localparam int          CTRL_WCLR_BIT   = 2;
  localparam int          CTRL_SBCLR_BIT  = 3;
  localparam int          CTRL_DETEN_BIT  = 4;
  localparam int          CTRL_THR_LSB    = 5;
  localparam int          CTRL_THR_W      = 3;
  localparam int          CTRL_BKP_BIT    = 8;

  // ----------------------------------------------------------------
  // power_state field positions
  // ----------------------------------------------------------------
  localparam int          STAT_WAKE_BIT   = 0;
  localparam int          STAT_SB_BIT     = 1;
  localparam int          STAT_BELOW_BIT  = 2;
  localparam int          STAT_PIN_LSB    = 8;

  // ----------------------------------------------------------------
  // reset values, cycle counts and wake pin count
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] STAT_RESET      = 32'h0000_0000;
  localparam int          WAKE_CLR_CYCLES = 2;
  localparam int          WAKE_PINS       = 8;

  // power mode of the device
  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_STOP,
    PMC_STANDBY
  } pmc_mode_t;

endpackage

// ### src/pmc_power_regs.sv
// power mode control and status registers on the apb peripheral bus
`timescale 1ns/1ps
`default_nettype none

// How it works
// - control bit 0 puts the regulator in low power while in stop mode
// - control bit 1 picks standby (1) or stop (0) on deep sleep
// - writing 1 to control bit 2 clears wake flag two cycles later
// - writing 1 to control bit 3 clears the standby flag
// - control bit 4 enables the supply voltage detector
// - control bits 7:5 pick detector threshold, 2.2 V to 2.9 V
// - control bit 8 allows writes to backup domain; blocked after reset
// - control register resets to zero and clears on standby wake
// - status register resets to zero and survives standby wake
// - status reads take one extra bus cycle; master must wait
// - status bit 0 set by enabled wake pin high or rtc wake
// - status bit 1 set on standby entry; cleared by reset or clear bit
// - status bit 2 shows supply below threshold while detector runs outside standby
// - below-threshold bit is zero after reset and on standby entry
// - status bits 15:8 let each wake pin wake the device
// - wake pin enables clear on system reset
// - deep sleep with standby select and no wake flag enters standby
// - deep sleep with standby select low enters stop mode
module pmc_power_regs #(
  parameter int ADDR_W = 8,
  parameter int PINS   = pmc_pkg::WAKE_PINS
) (
  input  wire logic              ref_clk,                   // 10 MHz clock
  input  wire logic              sys_rst,                   // power-on reset
  input  wire logic              psel,                      // apb select
  input  wire logic              penable,                   // apb enable
  input  wire logic              pwrite,                    // apb write
  input  wire logic [ADDR_W-1:0] paddr,                     // apb address
  input  wire logic [31:0]       pwdata,                    // apb wdata
  output logic [31:0]            prdata,                    // apb rdata
  output logic                   pready,                    // apb ready
  output logic                   pslverr,                   // apb error
  input  wire logic [PINS-1:0]   wake_pin,                  // wake pins
  input  wire logic              rtc_alarm_wake,            // rtc wake
  input  wire logic              sleep_instr,               // wfi/wfe pulse
  input  wire logic              core_deep_sleep_bit,       // core deep
  input  wire logic              stop_wake_req,             // irq/event
  input  wire logic              standby_ext_reset,         // pin/wdt rst
  input  wire logic              supply_below_raw,          // comparator
  output logic                   stop_regulator_lowpower,   // ctrl bit
  output logic                   deep_sleep_standby_select, // ctrl bit
  output logic                   voltage_detector_enable,   // ctrl bit
  output logic [2:0]             detector_threshold_select, // ctrl field
  output logic                   backup_write_enable,       // ctrl bit
  output logic [PINS-1:0]        wake_pin_config,           // pin enables
  output logic                   regulator_lowpower_on,     // lp in stop
  output logic                   in_stop,                   // stop mode
  output logic                   in_standby                 // standby mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               lp;
    logic               sb_sel;
    logic               det_en;
    logic [2:0]         thr;
    logic               bkp;
    logic [PINS-1:0]    pin_cfg;
    logic               wake_flag;
    logic               sb_flag;
    logic               below;
    logic               lp_on;
    pmc_pkg::pmc_mode_t mode;
    logic               waited;
    logic [31:0]        rdata;
  } pmc_regs_state_t;

  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(pmc_pkg::CTRL_OFS);
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(pmc_pkg::STAT_OFS);

  pmc_regs_state_t s_r;
  pmc_regs_state_t s_nxt;

  logic        setup_ph;
  logic        access_ph;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        stat_rd;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wclr_req;
  logic        wclr_fire;
  logic        sbclr;
  logic        wake_any;
  logic        sleep_go;
  logic        enter_sb;
  logic        enter_stop;
  logic        sb_exit;
  logic        stop_exit;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  pmc_wake_detect #(
    .PINS            (PINS)
  ) u_wake (
    .wake_pin        (wake_pin),
    .wake_pin_config (s_r.pin_cfg),
    .rtc_alarm_wake  (rtc_alarm_wake),
    .wake_any        (wake_any)
  );

  pmc_clear_delay #(
    .DEPTH    (pmc_pkg::WAKE_CLR_CYCLES)
  ) u_wclr (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clr_req  (wclr_req),
    .clr_fire (wclr_fire)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // address decode, unmapped offsets answer with an error
  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (paddr == A_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr == A_STAT) begin
      hit_stat = 1'b1;
    end
  end

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign stat_rd   = access_ph & ~pwrite & hit_stat;
  // status read holds ready low for its first access cycle
  assign pready    = ~(stat_rd & ~s_r.waited);
  assign pslverr   = access_ph & pready & ~(hit_ctrl | hit_stat);
  assign wr_ctrl   = access_ph & pready & pwrite & hit_ctrl;
  assign wr_stat   = access_ph & pready & pwrite & hit_stat;
  assign wclr_req  = wr_ctrl & pwdata[pmc_pkg::CTRL_WCLR_BIT];
  assign sbclr     = wr_ctrl & pwdata[pmc_pkg::CTRL_SBCLR_BIT];

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  // clear strobes are never stored, so they read zero
  always_comb begin
    ctrl_word                            = '0;
    ctrl_word[pmc_pkg::CTRL_LP_BIT]      = s_r.lp;
    ctrl_word[pmc_pkg::CTRL_SBSEL_BIT]   = s_r.sb_sel;
    ctrl_word[pmc_pkg::CTRL_WCLR_BIT]    = 1'b0;
    ctrl_word[pmc_pkg::CTRL_SBCLR_BIT]   = 1'b0;
    ctrl_word[pmc_pkg::CTRL_DETEN_BIT]   = s_r.det_en;
    ctrl_word[pmc_pkg::CTRL_THR_LSB +: pmc_pkg::CTRL_THR_W] = s_r.thr;
    ctrl_word[pmc_pkg::CTRL_BKP_BIT]     = s_r.bkp;
  end

  always_comb begin
    stat_word                            = '0;
    stat_word[pmc_pkg::STAT_WAKE_BIT]    = s_r.wake_flag;
    stat_word[pmc_pkg::STAT_SB_BIT]      = s_r.sb_flag;
    stat_word[pmc_pkg::STAT_BELOW_BIT]   = s_r.below;
    stat_word[pmc_pkg::STAT_PIN_LSB +: PINS] = s_r.pin_cfg;
  end

  // ----------------------------------------------------------------
  // power mode events
  // ----------------------------------------------------------------
  // sleep with the deep bit clear is plain sleep and never reaches us
  assign sleep_go   = sleep_instr & core_deep_sleep_bit &
                      (s_r.mode == pmc_pkg::PMC_RUN);
  // a pending wake flag blocks standby so no event is slept through
  assign enter_sb   = sleep_go & s_r.sb_sel & ~s_r.wake_flag;
  assign enter_stop = sleep_go & ~s_r.sb_sel;
  assign sb_exit    = (s_r.mode == pmc_pkg::PMC_STANDBY) &
                      (wake_any | standby_ext_reset);
  assign stop_exit  = (s_r.mode == pmc_pkg::PMC_STOP) &
                      (wake_any | stop_wake_req);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.waited = stat_rd & ~s_r.waited;

    // read data is sampled in setup and again in the wait cycle
    if ((setup_ph & ~pwrite) | (stat_rd & ~s_r.waited)) begin
      if (hit_ctrl) begin
        s_nxt.rdata = ctrl_word;
      end else if (hit_stat) begin
        s_nxt.rdata = stat_word;
      end else begin
        s_nxt.rdata = '0;
      end
    end

    // control writes, reserved bits dropped
    if (wr_ctrl) begin
      s_nxt.lp     = pwdata[pmc_pkg::CTRL_LP_BIT];
      s_nxt.sb_sel = pwdata[pmc_pkg::CTRL_SBSEL_BIT];
      s_nxt.det_en = pwdata[pmc_pkg::CTRL_DETEN_BIT];
      s_nxt.thr    = pwdata[pmc_pkg::CTRL_THR_LSB +: pmc_pkg::CTRL_THR_W];
      s_nxt.bkp    = pwdata[pmc_pkg::CTRL_BKP_BIT];
    end

    // only the pin enables of the status word are writable
    if (wr_stat) begin
      s_nxt.pin_cfg = pwdata[pmc_pkg::STAT_PIN_LSB +: PINS];
    end

    // wake flag: a new event beats the delayed clear
    if (wake_any) begin
      s_nxt.wake_flag = 1'b1;
    end else if (wclr_fire) begin
      s_nxt.wake_flag = 1'b0;
    end

    // standby flag: entry beats a clear in the same cycle
    if (enter_sb) begin
      s_nxt.sb_flag = 1'b1;
    end else if (sbclr) begin
      s_nxt.sb_flag = 1'b0;
    end

    // comparator output only counts while the detector runs
    s_nxt.below = s_r.det_en & supply_below_raw &
                  (s_r.mode != pmc_pkg::PMC_STANDBY);
    if (enter_sb) begin
      s_nxt.below = 1'b0;
    end

    // mode sequencing
    case (s_r.mode)
      pmc_pkg::PMC_RUN: begin
        if (enter_sb) begin
          s_nxt.mode = pmc_pkg::PMC_STANDBY;
        end else if (enter_stop) begin
          s_nxt.mode = pmc_pkg::PMC_STOP;
        end
      end
      pmc_pkg::PMC_STOP: begin
        if (stop_exit) begin
          s_nxt.mode = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_STANDBY: begin
        if (sb_exit) begin
          s_nxt.mode = pmc_pkg::PMC_RUN;
        end
      end
      default: begin
        s_nxt.mode = pmc_pkg::PMC_RUN;
      end
    endcase

    // standby wake is a chip reset for control only; status is kept
    if (sb_exit) begin
      s_nxt.lp     = 1'b0;
      s_nxt.sb_sel = 1'b0;
      s_nxt.det_en = 1'b0;
      s_nxt.thr    = '0;
      s_nxt.bkp    = 1'b0;
    end

    // regulator drops to low power only while actually stopped
    s_nxt.lp_on = (s_nxt.mode == pmc_pkg::PMC_STOP) & s_nxt.lp;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // power-on reset clears everything, pin enables included
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                    = s_r.rdata;
  assign stop_regulator_lowpower   = s_r.lp;
  assign deep_sleep_standby_select = s_r.sb_sel;
  assign voltage_detector_enable   = s_r.det_en;
  assign detector_threshold_select = s_r.thr;
  assign backup_write_enable       = s_r.bkp;
  assign wake_pin_config           = s_r.pin_cfg;
  assign regulator_lowpower_on     = s_r.lp_on;
  assign in_stop                   = s_r.mode == pmc_pkg::PMC_STOP;
  assign in_standby                = s_r.mode == pmc_pkg::PMC_STANDBY;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_stat_read_wait: assert property (
    (stat_rd && !s_r.waited) |-> !pready ##1 (pready && stat_rd)
  ) else $error("status read did not take exactly one wait cycle");

  a_wake_clr_late: assert property (
    (wclr_req ##1 !wake_any [*2]) |-> ##1 !s_r.wake_flag
  ) else $error("wake flag not cleared after delayed clear");

  a_wake_set_now: assert property (
    wake_any |=> s_r.wake_flag
  ) else $error("wake event did not set the wake flag");

  a_sb_flag_sticky: assert property (
    (s_r.sb_flag && !sbclr) |=> s_r.sb_flag
  ) else $error("standby flag dropped without a clear");

  a_sb_flag_clear: assert property (
    (sbclr && !enter_sb) |=> !s_r.sb_flag
  ) else $error("standby flag clear write had no effect");

  a_sb_entry: assert property (
    enter_sb |=> (in_standby && s_r.sb_flag && !s_r.below)
  ) else $error("standby entry did not update mode and flags");

  a_sb_blocked: assert property (
    (sleep_go && s_r.sb_sel && s_r.wake_flag) |=>
      (s_r.mode == pmc_pkg::PMC_RUN)
  ) else $error("standby entered with wake flag pending");

  a_stop_entry: assert property (
    enter_stop |=> in_stop ##0 (regulator_lowpower_on == s_r.lp)
  ) else $error("stop entry or regulator state wrong");

  a_ctrl_on_wake: assert property (
    (sb_exit && !sbclr) |=>
      (ctrl_word == pmc_pkg::CTRL_RESET) && $stable(s_r.sb_flag)
  ) else $error("control not cleared or status lost on standby wake");

  a_below_needs_en: assert property (
    s_r.below |-> ($past(s_r.det_en) && !in_standby)
  ) else $error("below flag set while detector off");

  a_read_zero_bits: assert property (
    (access_ph && pready && !pwrite && hit_ctrl) |->
      (prdata[3:2] == 2'b00 && prdata[31:9] == '0)
  ) else $error("control read shows strobe or reserved bits");

endmodule

`default_nettype wire

// ### src/pmc_wake_detect.sv
// masks the wake pins with their enables and merges them with the rtc wake
`timescale 1ns/1ps
`default_nettype none

module pmc_wake_detect #(
  parameter int PINS = 8
) (
  input  wire logic [PINS-1:0] wake_pin,        // wake pin levels
  input  wire logic [PINS-1:0] wake_pin_config, // per pin wake enable
  input  wire logic            rtc_alarm_wake,  // rtc alarm wake level
  output logic                 wake_any         // any enabled wake event
);

  logic [PINS-1:0] pin_hit;

  // ----------------------------------------------------------------
  // per pin gate: a pin left as plain i/o never wakes the device
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    assign pin_hit[i] = wake_pin[i] & wake_pin_config[i];
  end

  // high level on an enabled pin counts as an event
  assign wake_any = (|pin_hit) | rtc_alarm_wake;

endmodule

`default_nettype wire

// ### tb/pmc_power_regs_test.sv
// self-checking bench for the power mode control and status registers
`timescale 1ns/1ps
`default_nettype none

module pmc_power_regs_test;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic [7:0]  wake_pin = 8'h00;
  logic        rtc_alarm_wake = 1'b0, sleep_instr = 1'b0;
  logic        core_deep_sleep_bit = 1'b0, stop_wake_req = 1'b0;
  logic        standby_ext_reset = 1'b0, supply_below_raw = 1'b0;
  logic        lp, sel, det, bkp, reg_lp, in_stop, in_standby;
  logic [2:0]  thr;
  logic [7:0]  pin_cfg;
  logic [31:0] rd, d;
  logic        err;
  int          waits, errors = 0, comparisons = 0;

  always #50 ref_clk = ~ref_clk;

  pmc_power_regs dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
    .rtc_alarm_wake(rtc_alarm_wake), .sleep_instr(sleep_instr),
    .core_deep_sleep_bit(core_deep_sleep_bit),
    .stop_wake_req(stop_wake_req), .standby_ext_reset(standby_ext_reset),
    .supply_below_raw(supply_below_raw), .stop_regulator_lowpower(lp),
    .deep_sleep_standby_select(sel), .voltage_detector_enable(det),
    .detector_threshold_select(thr), .backup_write_enable(bkp),
    .wake_pin_config(pin_cfg), .regulator_lowpower_on(reg_lp),
    .in_stop(in_stop), .in_standby(in_standby));

  // ----------------------------------------------------------------
  // expectation functions
  // ----------------------------------------------------------------
  // only the stored control bits survive; strobes and reserved read zero
  function automatic logic [31:0] exp_ctrl(input logic [31:0] v);
    return v & 32'h0000_01F3;
  endfunction

  // control outputs packed back into the control word layout
  function automatic logic [31:0] ctrl_outs();
    return {23'h0, bkp, thr, det, 2'b00, sel, lp};
  endfunction

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer; a ready hung for 8 cycles fails the run and ends the sim
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] v);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    waits = 0;
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
      waits++;
    end
    if (i == 8) begin
      errors++;
      $display("CHECK FAILED pready expected 1 seen 0");
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle pulse on a sideband input, then one edge to land
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: sleep_instr <= 1'b1;
      1: stop_wake_req <= 1'b1;
      2: standby_ext_reset <= 1'b1;
      3: rtc_alarm_wake <= 1'b1;
      default: wake_pin <= 8'h01;
    endcase
    @(posedge ref_clk);
    {sleep_instr, stop_wake_req, standby_ext_reset, rtc_alarm_wake} <= 4'h0;
    wake_pin <= 8'h00;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(71700));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk("ctrl_reset", pmc_pkg::CTRL_OFS, pmc_pkg::CTRL_RESET);
    check("ctrl_waits", waits, 0);
    rd_chk("stat_reset", pmc_pkg::STAT_OFS, pmc_pkg::STAT_RESET);
    check("stat_waits", waits, 1);
    check("bkp_reset", bkp, 1'b0);
    pulse(0);
    check("no_deep_sleep", {in_stop, in_standby}, 2'b00);
    // random control and pin enable words; enables cleared before pins move
    repeat (10) begin
      d = $urandom;
      apb(1'b1, pmc_pkg::CTRL_OFS, d);
      rd_chk("ctrl_rand", pmc_pkg::CTRL_OFS, exp_ctrl(d));
      check("ctrl_outs", ctrl_outs(), exp_ctrl(d));
      d = $urandom;
      apb(1'b1, pmc_pkg::STAT_OFS, d);
      check("stat_wr_waits", waits, 0);
      rd_chk("stat_rand", pmc_pkg::STAT_OFS, d & 32'h0000_FF00);
      check("pin_cfg", pin_cfg, d[15:8]);
      apb(1'b1, pmc_pkg::STAT_OFS, 32'h0);
      wake_pin <= 8'($urandom);
      rd_chk("masked_pins", pmc_pkg::STAT_OFS, 32'h0);
      wake_pin <= 8'h00;
    end
    // unmapped accesses are refused and leave control alone
    apb(1'b1, pmc_pkg::CTRL_OFS, 32'h0000_0011);
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped_rd", rd, 32'h0);
    check("unmapped_rd_err", err, 1'b1);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    check("unmapped_err", err, 1'b1);
    rd_chk("ctrl_kept", pmc_pkg::CTRL_OFS, 32'h0000_0011);
    // second reset in mid-run clears both words
    apb(1'b1, pmc_pkg::CTRL_OFS, 32'hFFFF_FFFF);
    apb(1'b1, pmc_pkg::STAT_OFS, 32'hFFFF_FFFF);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk("ctrl_rst2", pmc_pkg::CTRL_OFS, 32'h0);
    rd_chk("stat_rst2", pmc_pkg::STAT_OFS, 32'h0);
    // wake flag: disabled pin ignored, enabled pin and rtc set, clear strobe
    apb(1'b1, pmc_pkg::STAT_OFS, 32'h0000_0100);
    wake_pin <= 8'h02;
    rd_chk("pin_off", pmc_pkg::STAT_OFS, 32'h0000_0100);
    pulse(4);
    rd_chk("pin_wake", pmc_pkg::STAT_OFS, 32'h0000_0101);
    apb(1'b1, pmc_pkg::CTRL_OFS, 32'h0000_0004);
    repeat (2) @(posedge ref_clk);
    rd_chk("wake_clr", pmc_pkg::STAT_OFS, 32'h0000_0100);
    rd_chk("clr_reads_0", pmc_pkg::CTRL_OFS, 32'h0);
    pulse(3);
    rd_chk("rtc_wake", pmc_pkg::STAT_OFS, 32'h0000_0101);
    // stop mode with either regulator setting
    core_deep_sleep_bit <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, pmc_pkg::CTRL_OFS, 32'(k));
      pulse(0);
      check("stop_in", {in_stop, in_standby}, 2'b10);
      check("reg_lp", reg_lp, k[0]);
      pulse(1);
      check("stop_out", in_stop, 1'b0);
    end
    // standby refused while wake flag is set
    apb(1'b1, pmc_pkg::CTRL_OFS, 32'h0000_0002);
    pulse(0);
    check("sb_blocked", {in_stop, in_standby}, 2'b00);
    supply_below_raw <= 1'b1;
    apb(1'b1, pmc_pkg::CTRL_OFS, 32'h0000_01F6);
    repeat (2) @(posedge ref_clk);
    rd_chk("below_set", pmc_pkg::STAT_OFS, 32'h0000_0104);
    check("det_outs", ctrl_outs(), 32'h0000_01F2);
    pulse(0);
    check("sb_in", in_standby, 1'b1);
    rd_chk("sb_stat", pmc_pkg::STAT_OFS, 32'h0000_0102);
    pulse(2);
    check("sb_out", in_standby, 1'b0);
    rd_chk("ctrl_wake_clr", pmc_pkg::CTRL_OFS, 32'h0);
    check("bkp_closed", bkp, 1'b0);
    rd_chk("stat_kept", pmc_pkg::STAT_OFS, 32'h0000_0102);
    apb(1'b1, pmc_pkg::CTRL_OFS, 32'h0000_0008);
    rd_chk("sb_clr", pmc_pkg::STAT_OFS, 32'h0000_0100);
    // stop left through an enabled wake pin, which also raises the flag
    apb(1'b1, pmc_pkg::CTRL_OFS, 32'h0000_0001);
    pulse(0);
    check("stop_in_lp", {in_stop, reg_lp}, 2'b11);
    pulse(4);
    check("stop_pin_out", {in_stop, reg_lp}, 2'b00);
    rd_chk("stop_pin_flag", pmc_pkg::STAT_OFS, 32'h0000_0101);
    conclude();
  end
endmodule

`default_nettype wire
